// ### eep_map.svh
// Bit positions, codes and timing counts for the two-wire EEPROM link
`ifndef EEP_MAP_SVH
`define EEP_MAP_SVH

// Clock and timing
`define EEP_CLK_PERIOD_NS 5
`define EEP_WRITE_TIME_NS 1000000
`define EEP_WRITE_CYCLES (`EEP_WRITE_TIME_NS / `EEP_CLK_PERIOD_NS)
`define EEP_SCL_QUARTER_NS 2500
`define EEP_SCL_QUARTER_CYCLES (`EEP_SCL_QUARTER_NS / `EEP_CLK_PERIOD_NS)
`define EEP_QUARTER_W 10

// Control byte layout
`define EEP_CODE_MSB 7
`define EEP_CODE_LSB 4
`define EEP_CS_MSB 3
`define EEP_CS_LSB 1
`define EEP_RW_BIT 0
`define EEP_CTRL_CODE 4'ha
`define EEP_RW_READ 1'b1
`define EEP_RW_WRITE 1'b0

// Byte framing and array
`define EEP_ACK_SLOT 4'h8
`define EEP_LAST_TX_BIT 4'h7
`define EEP_ADDR_W 7
`define EEP_DEPTH 128
`define EEP_PAGE_LSB_W 4

`endif

// ### eep_pkg.sv
// Types shared by both ends of the two-wire EEPROM link
package eep_pkg;
    // Slave bus states
    typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_RX_ACK, DS_TX, DS_TX_ACK} eep_dev_state_t;
    // Which byte the slave is taking in
    typedef enum logic [1:0] {RK_CTRL, RK_ADDR, RK_DATA} eep_rx_kind_t;
    // Master bus units
    typedef enum logic [2:0] {MS_IDLE, MS_START, MS_TX, MS_RX, MS_STOP} eep_mst_state_t;
    // Master progress inside a command
    typedef enum logic [2:0] {PH_CTRL_W, PH_ADDR, PH_DATA, PH_CTRL_R, PH_READ} eep_phase_t;
    // Commands the master accepts
    typedef enum logic [1:0] {CMD_WRITE, CMD_POLL, CMD_READ_CUR, CMD_READ_RAND} eep_cmd_t;
    // Kind of bit slot on the wire
    typedef enum logic [1:0] {BK_START, BK_STOP, BK_DATA} eep_bit_t;
endpackage : eep_pkg

// ### eep_if.sv
// Open-drain two-wire bus joining master and slave
interface eep_if;
    // Pull-down enables, high while a party pulls the line low
    logic scl_mst_oe;
    logic sda_mst_oe;
    logic sda_dev_oe;
    // Resolved line levels with pull-ups
    logic scl;
    logic sda;
    assign scl = ~scl_mst_oe;
    assign sda = ~(sda_mst_oe | sda_dev_oe);
    modport dev (input scl, input sda, output sda_dev_oe);
    modport mst (input scl, input sda, output scl_mst_oe, output sda_mst_oe);
endinterface : eep_if

// ### eep_device.sv
// Two-wire EEPROM slave: control decode, ack polling, write cycle and reads
`include "eep_map.svh"

// Behaviour
// - No acknowledge while write cycle runs
// - STOP after write starts timed write cycle
// - Master polls with START plus write control
// - Master repeats poll until acknowledged
// - Acknowledge polling control once cycle ends
// - Control byte last bit one selects read
// - Counter holds last location plus one
// - Acknowledge read control, send counter's byte
// - Master nack ends read; release data line
// - Repeated START after address aborts write
// - Read control after restart returns addressed byte
// - After random read counter points past byte
// - Each master acknowledge sends next byte
// - Pointer advances by one per byte
// - Pointer wraps from 7F to 00; write advance wraps within the 16-byte page instead, 7F to 70
// - Control code 1010 required, others ignored
// - Chip-select bits must match strap pins
// - Word address byte loads address pointer
module eep_device #(
    parameter int WRITE_CYCLES = `EEP_WRITE_CYCLES
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // Two-wire bus
    eep_if.dev BUS,
    // Strap pins
    input wire logic [2:0] CHIP_SELECT_STRAPS,
    // Status
    output logic WRITE_BUSY
);
    import eep_pkg::*;

    localparam int BUSY_W = $clog2(WRITE_CYCLES + 1);

    // Storage array, no reset
    logic [7:0] mem [`EEP_DEPTH];

    eep_dev_state_t state_reg;
    eep_rx_kind_t kind_reg;
    logic [7:0] shift_reg;
    logic [3:0] cnt_reg;
    logic [`EEP_ADDR_W-1:0] ptr_reg;
    logic rw_reg;
    logic written_reg;
    logic sda_oe_reg;
    logic scl_p_reg;
    logic sda_p_reg;
    logic busy_reg;
    logic [BUSY_W-1:0] busy_cnt_reg;

    // Full-width advance, rolls over at the top
    function automatic logic [`EEP_ADDR_W-1:0] ptr_inc(input logic [`EEP_ADDR_W-1:0] p);
        ptr_inc = p + 7'h01;
    endfunction : ptr_inc

    // Write advance stays within the page
    function automatic logic [`EEP_ADDR_W-1:0] page_inc(input logic [`EEP_ADDR_W-1:0] p);
        page_inc = {p[`EEP_ADDR_W-1:`EEP_PAGE_LSB_W], p[`EEP_PAGE_LSB_W-1:0] + 4'h1};
    endfunction : page_inc

    // Bus event decode
    wire scl_rise = BUS.scl & ~scl_p_reg;
    wire scl_fall = ~BUS.scl & scl_p_reg;
    wire start_cond = BUS.scl & scl_p_reg & sda_p_reg & ~BUS.sda;
    wire stop_cond = BUS.scl & scl_p_reg & ~sda_p_reg & BUS.sda;

    // Control byte match
    wire code_ok = shift_reg[`EEP_CODE_MSB:`EEP_CODE_LSB] == `EEP_CTRL_CODE;
    wire cs_ok = shift_reg[`EEP_CS_MSB:`EEP_CS_LSB] == CHIP_SELECT_STRAPS;
    wire ctrl_ok = code_ok & cs_ok & ~busy_reg;

    // End of a received byte and its acknowledge decision
    wire byte_in = (state_reg == DS_RX) & scl_fall & (cnt_reg == `EEP_ACK_SLOT);
    wire give_ack = (kind_reg != RK_CTRL) | ctrl_ok;
    wire mem_we = byte_in & (kind_reg == RK_DATA);
    wire [7:0] rd_byte = mem[ptr_reg];
    wire go_read = (kind_reg == RK_CTRL) & (rw_reg == `EEP_RW_READ);

    assign BUS.sda_dev_oe = sda_oe_reg;
    assign WRITE_BUSY = busy_reg;

    // Line history for edge and condition detection
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_p_reg <= 1'b1;
            sda_p_reg <= 1'b1;
        end else begin
            scl_p_reg <= BUS.scl;
            sda_p_reg <= BUS.sda;
        end
    end

    // Array write on each accepted data byte
    always_ff @(posedge REF_CLK) begin
        if (mem_we) begin
            mem[ptr_reg] <= shift_reg;
        end
    end

    // Self-timed write cycle
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            busy_cnt_reg <= '0;
            busy_reg <= 1'b0;
        end else if (stop_cond && written_reg && !busy_reg) begin
            busy_cnt_reg <= BUSY_W'(WRITE_CYCLES);
            busy_reg <= 1'b1;
        end else if (busy_cnt_reg > BUSY_W'(1)) begin
            busy_cnt_reg <= busy_cnt_reg - BUSY_W'(1);
        end else begin
            busy_cnt_reg <= '0;
            busy_reg <= 1'b0;
        end
    end

    // Byte engine
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= DS_IDLE;
            kind_reg <= RK_CTRL;
            shift_reg <= 8'h00;
            cnt_reg <= 4'h0;
            ptr_reg <= '0;
            rw_reg <= `EEP_RW_WRITE;
            written_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (start_cond) begin
            // Any start, repeated or not, restarts at the control byte; bytes already written and written_reg are kept
            state_reg <= DS_RX;
            kind_reg <= RK_CTRL;
            cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
        end else if (stop_cond) begin
            state_reg <= DS_IDLE;
            sda_oe_reg <= 1'b0;
            written_reg <= 1'b0;
        end else begin
            case (state_reg)
                DS_RX: begin
                    if (scl_rise && cnt_reg != `EEP_ACK_SLOT) begin
                        shift_reg <= {shift_reg[6:0], BUS.sda};
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (byte_in) begin
                        cnt_reg <= 4'h0;
                        if (give_ack) begin
                            sda_oe_reg <= 1'b1;
                            state_reg <= DS_RX_ACK;
                        end else begin
                            // Line stays released across the ninth pulse
                            state_reg <= DS_IDLE;
                        end
                        if (kind_reg == RK_CTRL) begin
                            rw_reg <= shift_reg[`EEP_RW_BIT];
                        end
                        if (kind_reg == RK_ADDR) begin
                            ptr_reg <= shift_reg[`EEP_ADDR_W-1:0];
                        end
                        if (kind_reg == RK_DATA) begin
                            ptr_reg <= page_inc(ptr_reg);
                            written_reg <= 1'b1;
                        end
                    end
                end
                DS_RX_ACK: begin
                    if (scl_fall) begin
                        if (go_read) begin
                            // First byte comes from the counter's location
                            state_reg <= DS_TX;
                            shift_reg <= rd_byte;
                            sda_oe_reg <= ~rd_byte[7];
                            ptr_reg <= ptr_inc(ptr_reg);
                        end else begin
                            state_reg <= DS_RX;
                            sda_oe_reg <= 1'b0;
                            kind_reg <= (kind_reg == RK_CTRL) ? RK_ADDR : RK_DATA;
                        end
                    end
                end
                DS_TX: begin
                    if (scl_fall) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg == `EEP_LAST_TX_BIT) begin
                            sda_oe_reg <= 1'b0;
                            state_reg <= DS_TX_ACK;
                        end else begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            sda_oe_reg <= ~shift_reg[6];
                        end
                    end
                end
                DS_TX_ACK: begin
                    if (scl_rise && BUS.sda) begin
                        // Master declined: stay off the line until next start
                        state_reg <= DS_IDLE;
                    end else if (scl_fall) begin
                        state_reg <= DS_TX;
                        cnt_reg <= 4'h0;
                        shift_reg <= rd_byte;
                        sda_oe_reg <= ~rd_byte[7];
                        ptr_reg <= ptr_inc(ptr_reg);
                    end
                end
                default: begin
                    state_reg <= DS_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end
endmodule : eep_device

// ### eep_master.sv
// Two-wire bus master: writes, ack polling and reads with a two-entry buffer
`include "eep_map.svh"

module eep_master #(
    parameter int QUARTER_CYCLES = `EEP_SCL_QUARTER_CYCLES
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // Two-wire bus
    eep_if.mst BUS,
    // Command port
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire eep_pkg::eep_cmd_t CMD_KIND,
    input wire logic [2:0] CMD_CHIP,
    input wire logic [6:0] CMD_ADDR,
    input wire logic [7:0] CMD_WDATA,
    input wire logic [7:0] CMD_LEN,
    output logic CMD_DONE,
    output logic CMD_NACK,
    // Read data stream
    output logic RD_VALID,
    input wire logic RD_READY,
    output logic [7:0] RD_DATA
);
    import eep_pkg::*;

    eep_mst_state_t state_reg;
    eep_phase_t phase_reg;
    eep_cmd_t kind_reg;
    logic [2:0] chip_reg;
    logic [6:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] left_reg;
    logic [7:0] sh_reg;
    logic [3:0] bc_reg;
    logic [1:0] q_reg;
    logic [`EEP_QUARTER_W-1:0] qt_reg;
    logic ack_reg;
    logic scl_oe_reg;
    logic sda_oe_reg;
    logic ready_reg;
    logic done_reg;
    logic nack_reg;
    logic [7:0] head_reg;
    logic [7:0] tail_reg;
    logic head_v_reg;
    logic tail_v_reg;

    // Control byte for this chip
    function automatic logic [7:0] ctrl_byte(input logic [2:0] cs, input logic rd);
        ctrl_byte = {`EEP_CTRL_CODE, cs, rd};
    endfunction : ctrl_byte

    // Line levels inside one bit slot, by quarter
    function automatic logic sda_level(input eep_bit_t k, input logic [1:0] q, input logic b);
        sda_level = (k == BK_START) ? (q < 2'd2) : (k == BK_STOP) ? (q >= 2'd2) : b;
    endfunction : sda_level

    function automatic logic scl_level(input eep_bit_t k, input logic [1:0] q);
        scl_level = (k == BK_STOP) ? (q != 2'd0) : (q == 2'd1 || q == 2'd2);
    endfunction : scl_level

    // Slot decode
    wire tick = qt_reg == '0;
    wire bit_end = tick & (q_reg == 2'd3);
    wire sample = tick & (q_reg == 2'd1);
    wire in_byte = bc_reg != `EEP_ACK_SLOT;
    wire more = left_reg != 8'h01;
    wire hold = (state_reg == MS_RX) & (bc_reg == 4'h0) & (q_reg == 2'd0) & tail_v_reg;
    wire eep_bit_t bk = (state_reg == MS_START) ? BK_START : (state_reg == MS_STOP) ? BK_STOP : BK_DATA;
    wire tx_bit = in_byte ? sh_reg[7] : 1'b1;
    wire rx_bit = in_byte ? 1'b1 : ~more; // Acknowledge only while bytes remain
    wire cur_bit = (state_reg == MS_RX) ? rx_bit : tx_bit;
    wire push = (state_reg == MS_RX) & bit_end & ~in_byte;
    wire pop = RD_READY & head_v_reg;
    wire accept = CMD_VALID & ready_reg;

    assign BUS.scl_mst_oe = scl_oe_reg;
    assign BUS.sda_mst_oe = sda_oe_reg;
    assign CMD_READY = ready_reg;
    assign CMD_DONE = done_reg;
    assign CMD_NACK = nack_reg;
    assign RD_VALID = head_v_reg;
    assign RD_DATA = head_reg;

    // Line drivers, released while idle
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else begin
            scl_oe_reg <= (state_reg != MS_IDLE) & ~scl_level(bk, q_reg);
            sda_oe_reg <= (state_reg != MS_IDLE) & ~sda_level(bk, q_reg, cur_bit);
        end
    end

    // Quarter timer, frozen while the buffer has no room
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            qt_reg <= '0;
            q_reg <= 2'd0;
        end else if (state_reg == MS_IDLE || hold) begin
            qt_reg <= `EEP_QUARTER_W'(QUARTER_CYCLES - 1);
            q_reg <= 2'd0;
        end else if (tick) begin
            qt_reg <= `EEP_QUARTER_W'(QUARTER_CYCLES - 1);
            q_reg <= q_reg + 2'd1;
        end else begin
            qt_reg <= qt_reg - `EEP_QUARTER_W'(1);
        end
    end

    // Two-entry read buffer
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            head_reg <= 8'h00;
            tail_reg <= 8'h00;
            head_v_reg <= 1'b0;
            tail_v_reg <= 1'b0;
        end else if (push && pop) begin
            head_reg <= tail_v_reg ? tail_reg : sh_reg;
            tail_reg <= sh_reg;
        end else if (push) begin
            if (!head_v_reg) begin
                head_reg <= sh_reg;
                head_v_reg <= 1'b1;
            end else begin
                tail_reg <= sh_reg;
                tail_v_reg <= 1'b1;
            end
        end else if (pop) begin
            head_reg <= tail_reg;
            head_v_reg <= tail_v_reg;
            tail_v_reg <= 1'b0;
        end
    end

    // Command sequencer
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= MS_IDLE;
            phase_reg <= PH_CTRL_W;
            kind_reg <= CMD_WRITE;
            chip_reg <= 3'h0;
            addr_reg <= 7'h00;
            wdata_reg <= 8'h00;
            left_reg <= 8'h00;
            sh_reg <= 8'h00;
            bc_reg <= 4'h0;
            ack_reg <= 1'b0;
            ready_reg <= 1'b1;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                MS_IDLE: begin
                    if (accept) begin
                        ready_reg <= 1'b0;
                        nack_reg <= 1'b0;
                        kind_reg <= CMD_KIND;
                        chip_reg <= CMD_CHIP;
                        addr_reg <= CMD_ADDR;
                        wdata_reg <= CMD_WDATA;
                        left_reg <= (CMD_LEN == 8'h00) ? 8'h01 : CMD_LEN;
                        phase_reg <= (CMD_KIND == CMD_READ_CUR) ? PH_CTRL_R : PH_CTRL_W;
                        state_reg <= MS_START;
                    end
                end
                MS_START: begin
                    if (bit_end) begin
                        sh_reg <= ctrl_byte(chip_reg, phase_reg == PH_CTRL_R);
                        bc_reg <= 4'h0;
                        state_reg <= MS_TX;
                    end
                end
                MS_TX: begin
                    if (sample && !in_byte) begin
                        ack_reg <= ~BUS.sda;
                    end
                    if (bit_end && in_byte) begin
                        sh_reg <= {sh_reg[6:0], 1'b0};
                        bc_reg <= bc_reg + 4'h1;
                    end else if (bit_end) begin
                        bc_reg <= 4'h0;
                        if (!ack_reg) begin
                            if (kind_reg == CMD_POLL) begin
                                state_reg <= MS_START;
                            end else begin
                                nack_reg <= 1'b1;
                                state_reg <= MS_STOP;
                            end
                        end else begin
                            case (phase_reg)
                                PH_CTRL_W: begin
                                    phase_reg <= PH_ADDR;
                                    sh_reg <= {1'b0, addr_reg};
                                    if (kind_reg == CMD_POLL) begin
                                        state_reg <= MS_STOP;
                                    end
                                end
                                PH_ADDR: begin
                                    if (kind_reg == CMD_WRITE) begin
                                        phase_reg <= PH_DATA;
                                        sh_reg <= wdata_reg;
                                    end else begin
                                        phase_reg <= PH_CTRL_R;
                                        state_reg <= MS_START;
                                    end
                                end
                                PH_CTRL_R: begin
                                    phase_reg <= PH_READ;
                                    state_reg <= MS_RX;
                                end
                                default: begin
                                    state_reg <= MS_STOP;
                                end
                            endcase
                        end
                    end
                end
                MS_RX: begin
                    if (sample && in_byte) begin
                        sh_reg <= {sh_reg[6:0], BUS.sda};
                    end
                    if (bit_end && in_byte) begin
                        bc_reg <= bc_reg + 4'h1;
                    end else if (bit_end) begin
                        bc_reg <= 4'h0;
                        left_reg <= left_reg - 8'h01;
                        state_reg <= more ? MS_RX : MS_STOP;
                    end
                end
                MS_STOP: begin
                    if (bit_end) begin
                        state_reg <= MS_IDLE;
                        ready_reg <= 1'b1;
                        done_reg <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= MS_IDLE;
                    ready_reg <= 1'b1;
                end
            endcase
        end
    end
endmodule : eep_master

// ### eep_link_assertions.sv
// Bus and busy-timer assertions for the two-wire EEPROM link
`include "eep_map.svh"

module eep_link_assertions #(
    parameter int WRITE_CYCLES = 50,
    parameter int QUARTER_CYCLES = `EEP_SCL_QUARTER_CYCLES
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // Bus lines and status
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_oe,
    input wire logic WRITE_BUSY
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HIGH_CYCLES = 2 * QUARTER_CYCLES;
    int busy_cnt;
    int high_cnt;
    logic pulse_armed;
    logic scl_q;
    logic sda_q;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);

    // Busy and SCL-high counters; arming skips the idle-high stretch
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            busy_cnt <= 0;
            high_cnt <= 0;
            pulse_armed <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            busy_cnt <= WRITE_BUSY ? busy_cnt + 1 : 0;
            high_cnt <= scl ? high_cnt + 1 : 0;
            scl_q <= scl;
            sda_q <= sda;
            if (scl && scl_q && sda && !sda_q) begin
                pulse_armed <= 1'b0;
            end else if (scl && !scl_q) begin
                pulse_armed <= 1'b1;
            end
        end
    end

    // Slave behaviour around the write cycle and the data line, and the clock high time
    a_busy_no_ack: assert property (WRITE_BUSY |-> !sda_dev_oe)
        else $error("Slave pulled data low while busy");
    a_busy_after_stop: assert property ($rose(WRITE_BUSY) |-> scl && sda)
        else $error("Busy began outside a stop");
    a_busy_length: assert property ($fell(WRITE_BUSY) |-> busy_cnt == WRITE_CYCLES)
        else $error("Busy length wrong");
    a_busy_min_hold: assert property ($rose(WRITE_BUSY) |=> WRITE_BUSY [*8])
        else $error("Busy dropped early");
    a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
        else $error("Slave changed data while clock high");
    a_dev_moves_low: assert property ($changed(sda_dev_oe) |-> !scl)
        else $error("Slave moved data with clock high");
    a_ack_min_hold: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*8])
        else $error("Slave pull-down too short");
    a_scl_high_time: assert property ($fell(scl) && pulse_armed |-> high_cnt == HIGH_CYCLES)
        else $error("Clock high time wrong");

    // Main scenarios reached
    c_busy_end: cover property ($fell(WRITE_BUSY));
    c_dev_drive: cover property ($rose(sda_dev_oe));
    c_start: cover property (scl && $past(scl) && $fell(sda));
endmodule : eep_link_assertions

// ### serial_eeprom_read_and_ack_poll_tb.sv
// Testbench joining master and slave: writes, polling, refusal and a wrapping read
module serial_eeprom_read_and_ack_poll_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import eep_pkg::*;
    localparam int BUSY_CYCLES = 1500;
    // Short bit quarter keeps the run brief
    localparam int QUARTER = 25;
    localparam logic [2:0] STRAPS = 3'h2;
    logic clk, resetn, cmd_valid, cmd_ready, cmd_done, cmd_nack, rd_valid, rd_ready, write_busy;
    eep_cmd_t cmd_kind;
    logic [2:0] cmd_chip;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_wdata, cmd_len, rd_data;
    logic [7:0] got[$];
    int fail_count, total_checks, last_cycles;

    // Both ends across one bus, checker beside it
    eep_if eep_if_inst ();
    eep_device #(.WRITE_CYCLES(BUSY_CYCLES)) eep_device_inst (.REF_CLK(clk), .RESETN(resetn),
        .BUS(eep_if_inst.dev), .CHIP_SELECT_STRAPS(STRAPS), .WRITE_BUSY(write_busy));
    eep_master #(.QUARTER_CYCLES(QUARTER)) eep_master_inst (.REF_CLK(clk), .RESETN(resetn), .BUS(eep_if_inst.mst),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_KIND(cmd_kind), .CMD_CHIP(cmd_chip),
        .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .CMD_LEN(cmd_len), .CMD_DONE(cmd_done),
        .CMD_NACK(cmd_nack), .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data));
    eep_link_assertions #(.WRITE_CYCLES(BUSY_CYCLES), .QUARTER_CYCLES(QUARTER)) eep_link_assertions_inst (
        .REF_CLK(clk), .RESETN(resetn), .scl(eep_if_inst.scl), .sda(eep_if_inst.sda),
        .sda_dev_oe(eep_if_inst.sda_dev_oe), .WRITE_BUSY(write_busy));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        total_checks++;
        if (act !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : check

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // One command; read stream held back for hold cycles, then drained
    task automatic run_cmd(input eep_cmd_t kind, input logic [6:0] addr, input logic [7:0] data,
                           input logic [7:0] len, input int hold, input logic [2:0] chip);
        int n;
        logic saw_done;
        got.delete();
        n = 0;
        saw_done = 1'b0;
        while (cmd_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        cmd_kind = kind;
        cmd_chip = chip;
        cmd_addr = addr;
        cmd_wdata = data;
        cmd_len = len;
        cmd_valid = 1'b1;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        while (n < 20000 && !(saw_done && rd_valid !== 1'b1)) begin
            @(posedge clk);
            #1;
            n++;
            if (cmd_done === 1'b1) begin
                saw_done = 1'b1;
                last_cycles = n;
            end
            if (hold > 0 && n == hold) begin
                check(rd_valid, 1);
                check(saw_done, 0);
            end
            rd_ready = (n > hold);
            if (rd_ready && rd_valid === 1'b1) begin
                got.push_back(rd_data);
            end
        end
        rd_ready = 1'b0;
        check(saw_done, 1);
    endtask : run_cmd

    task automatic t_write(input logic [6:0] addr, input logic [7:0] data);
        run_cmd(CMD_WRITE, addr, data, 8'h01, 0, STRAPS);
        check(cmd_nack, 0);
        check(write_busy, 1);
    endtask : t_write

    // Poll started at once: first try refused while busy, retry taken
    task automatic t_poll();
        run_cmd(CMD_POLL, 7'h00, 8'h00, 8'h01, 0, STRAPS);
        check(last_cycles > 64 * QUARTER, 1);
        check(cmd_nack, 0);
        check(write_busy, 0);
    endtask : t_poll

    // Chip bits that differ from the straps get no answer
    task automatic t_bad_chip();
        run_cmd(CMD_READ_CUR, 7'h00, 8'h00, 8'h01, 0, STRAPS ^ 3'h7);
        check(cmd_nack, 1);
        check(got.size(), 0);
    endtask : t_bad_chip

    // Random read at the top, running over the wrap, receiver stalling
    task automatic t_wrap_read();
        run_cmd(CMD_READ_RAND, 7'h7f, 8'h00, 8'h03, 6000, STRAPS);
        check(cmd_nack, 0);
        check(got[0], 8'h3c);
        check(got[1], 8'hc3);
        check(got[2], 8'h5a);
        check(got.size(), 3);
    endtask : t_wrap_read

    // Current-address read resumes just past the last byte read
    task automatic t_cur_read();
        run_cmd(CMD_READ_CUR, 7'h00, 8'h00, 8'h01, 0, STRAPS);
        check(cmd_nack, 0);
        check(got[0], 8'h96);
        check(got.size(), 1);
    endtask : t_cur_read

    // Watchdog over the expected run
    initial begin
        #250000;
        fail_count++;
        summarize();
    end

    // Reset, then the scenarios
    initial begin
        fail_count = 0;
        total_checks = 0;
        last_cycles = 0;
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_kind = CMD_WRITE;
        cmd_chip = 3'h0;
        cmd_addr = 7'h00;
        cmd_wdata = 8'h00;
        cmd_len = 8'h01;
        rd_ready = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        resetn = 1'b1;
        t_write(7'h7f, 8'h3c);
        t_poll();
        t_write(7'h00, 8'hc3);
        t_poll();
        t_write(7'h01, 8'h5a);
        t_poll();
        t_write(7'h02, 8'h96);
        t_poll();
        t_bad_chip();
        t_wrap_read();
        t_cur_read();
        summarize();
    end
endmodule : serial_eeprom_read_and_ack_poll_tb
